// *** gpc_defines.svh ***
// Offsets, field positions, reset values, pair count and channel codes of the output and calibration registers.
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH
`define GPC_ADDR_GPO        3'h5
`define GPC_ADDR_OFFSET     3'h6
`define GPC_ADDR_FULLSCALE  3'h7
`define GPC_GPO_RESET       8'h00
`define GPC_OFFSET_RESET    24'h800000
`define GPC_FULLSCALE_DEF   24'h555550
`define GPC_BIT_RESERVED    7
`define GPC_BIT_BRIDGE      6
`define GPC_BIT_UPPER_EN    5
`define GPC_BIT_LOWER_EN    4
`define GPC_NUM_PAIRS       5
`define GPC_LAST_PAIR       3'h4
`define GPC_PSEUDO_SHARED   4'h4
`define GPC_CHAN_SHORT      4'h9
`endif

// *** gpc_pkg.sv ***
// Types shared by the register bank and its coefficient store.
package gpc_pkg;
	typedef logic [23:0] gpc_coef_t;
	typedef logic [2:0] gpc_pair_t;
	typedef enum logic [1:0] {GPC_IDLE, GPC_WAIT} gpc_state_t;
endpackage

// *** gpc_coef_if.sv ***
// Bundle between the register front end and the coefficient store.
`timescale 1ns/1ps
interface gpc_coef_if;
	import gpc_pkg::*;
	logic      wrOffset;
	logic      wrFull;
	gpc_pair_t pair;
	gpc_coef_t wrData;
	gpc_coef_t rdOffset;
	gpc_coef_t rdFull;
	modport front (output wrOffset, wrFull, pair, wrData, input rdOffset, rdFull);
	modport store (input wrOffset, wrFull, pair, wrData, output rdOffset, rdFull);
endinterface

// *** gpc_coef_store.sv ***
// Five offset and five full-scale coefficient registers, one pair per channel group.
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_coef_store
	import gpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	gpc_coef_if.store bus
);
	typedef struct packed {
		gpc_coef_t [`GPC_NUM_PAIRS-1:0] offset;
		gpc_coef_t [`GPC_NUM_PAIRS-1:0] full;
	} gpc_store_t;
	gpc_store_t st;
	gpc_store_t next_st;
	always_comb
	begin
		next_st = st;
		if (bus.wrOffset)
			next_st.offset[bus.pair] = bus.wrData;
		if (bus.wrFull)
			next_st.full[bus.pair] = bus.wrData;
	end
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			// Same constant for every part here; a real part is trimmed per die.
			st.offset <= {`GPC_NUM_PAIRS{`GPC_OFFSET_RESET}};
			st.full <= {`GPC_NUM_PAIRS{`GPC_FULLSCALE_DEF}};
		end
		else
			st <= next_st;
	end
	// Both reads use one index so the pair stays matched.
	assign bus.rdOffset = st.offset[bus.pair];
	assign bus.rdFull = st.full[bus.pair];
	AST_OFFSET_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus.wrOffset && bus.pair <= `GPC_LAST_PAIR |=> st.offset[$past(bus.pair)] == $past(bus.wrData))
		else $error("Offset coefficient not stored.");
	AST_FULL_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		bus.wrFull && bus.pair <= `GPC_LAST_PAIR |=> st.full[$past(bus.pair)] == $past(bus.wrData))
		else $error("Full-scale coefficient not stored.");
endmodule

// *** gpc_regs.sv ***
// General-purpose output control register and calibration coefficient bank.
//
// Contract
// - Bit six set closes the bridge switch to ground; cleared opens it.
// - Bridge switch keeps its commanded state during converter power-down.
// - Bit five drives outputs three and two; clear tristates them, ignoring data.
// - Bit four drives outputs one and zero; clear tristates them, ignoring data.
// - With the pair enabled, each data bit sets its pin high or low.
// - Reading returns the real pin level for each enabled pin.
// - Reference select set turns pins one and zero into reference inputs.
// - Output control is eight bits, read and write, resets to zero, MSB first.
// - Each offset coefficient is 24 bits, read and write, resets to 0x800000.
// - Five offset registers; pseudo-differential channels beyond four share the fifth.
// - Zero-scale calibration start overwrites the selected offset register.
// - Five 24-bit full-scale registers, mapped to channels like the offsets.
// - Full-scale registers load a factory unity-gain coefficient at power-on.
// - Full-scale calibration start or a host write replaces the register.
// - Offset and matching full-scale register form one pair per channel group.
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_regs
	import gpc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic [2:0] registerSelect,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [23:0] regWriteData,
	output logic      [23:0] regReadData,
	output logic             regReadValid,
	input  wire logic [3:0] channelSelect,
	input  wire logic       pseudoMode,
	input  wire logic       referenceSelect,
	input  wire logic       zeroScaleCal,
	input  wire logic       fullScaleCal,
	input  wire logic [23:0] calResult,
	input  wire logic [3:0] pinLevelIn,
	output logic      [3:0] gpOut,
	output logic      [3:0] gpOutEnable,
	output logic            bridgeSwitchClosed
);
	typedef struct packed {
		logic [7:0]  gpControl;
		logic [23:0] readData;
		logic        readValid;
		logic [3:0]  pinOut;
		logic [3:0]  pinEnable;
		logic        bridge;
	} gpc_front_t;
	gpc_front_t st;
	gpc_front_t next_st;
	gpc_coef_if coef ();

	// Maps a channel code to its calibration pair; used for register access and calibration.
	function automatic gpc_pair_t pairOf(input logic [3:0] chan, input logic pseudo);
		gpc_pair_t p;
		p = 3'h0;
		if (chan == `GPC_CHAN_SHORT)
			p = 3'h0;
		else if (pseudo && chan >= `GPC_PSEUDO_SHARED && chan < 4'h8)
			p = `GPC_LAST_PAIR;
		else
			p = {1'b0, chan[1:0]};
		return p;
	endfunction

	// Readback mask follows the pair enable bits alone, so a pin lent to the reference still
	// reports its level while its pair is enabled.
	function automatic logic [3:0] pairEnMask(input logic [7:0] ctrl);
		return {{2{ctrl[`GPC_BIT_UPPER_EN]}}, {2{ctrl[`GPC_BIT_LOWER_EN]}}};
	endfunction

	gpc_pair_t curPair;
	logic      wrGpo;
	logic      wrOff;
	logic      wrFs;
	assign curPair = pairOf(channelSelect, pseudoMode);
	assign wrGpo = regWrite && registerSelect == `GPC_ADDR_GPO;
	assign wrOff = regWrite && registerSelect == `GPC_ADDR_OFFSET;
	assign wrFs = regWrite && registerSelect == `GPC_ADDR_FULLSCALE;

	// The host interface hands over a write only when every bit has shifted in, so
	// the pins never see a half-written value.
	always_comb
	begin
		coef.pair = curPair;
		coef.wrOffset = wrOff || zeroScaleCal;
		coef.wrFull = wrFs || fullScaleCal;
		coef.wrData = (zeroScaleCal || fullScaleCal) ? calResult : regWriteData;
	end

	logic [3:0] pinEnableNext;
	always_comb
	begin
		next_st = st;
		next_st.readValid = 1'b0;
		if (wrGpo)
			next_st.gpControl = regWriteData[7:0];
		next_st.bridge = next_st.gpControl[`GPC_BIT_BRIDGE];
		pinEnableNext[3] = next_st.gpControl[`GPC_BIT_UPPER_EN];
		pinEnableNext[2] = next_st.gpControl[`GPC_BIT_UPPER_EN];
		pinEnableNext[1] = next_st.gpControl[`GPC_BIT_LOWER_EN] && !referenceSelect;
		pinEnableNext[0] = next_st.gpControl[`GPC_BIT_LOWER_EN] && !referenceSelect;
		next_st.pinEnable = pinEnableNext;
		next_st.pinOut = next_st.gpControl[3:0] & pinEnableNext;
		if (regRead)
		begin
			next_st.readValid = 1'b1;
			case (registerSelect)
				`GPC_ADDR_GPO:
				begin
					next_st.readData = {16'h0000, st.gpControl[7:4],
						(st.gpControl[3:0] & ~pairEnMask(st.gpControl)) |
						(pinLevelIn & pairEnMask(st.gpControl))};
				end
				`GPC_ADDR_OFFSET:
					next_st.readData = coef.rdOffset;
				`GPC_ADDR_FULLSCALE:
					next_st.readData = coef.rdFull;
				default:
					next_st.readData = 24'h000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st.gpControl <= `GPC_GPO_RESET;
			st.readData <= 24'h000000;
			st.readValid <= 1'b0;
			st.pinOut <= 4'h0;
			st.pinEnable <= 4'h0;
			st.bridge <= 1'b0;
		end
		else
			st <= next_st;
	end

	gpc_coef_store u_store (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.bus     (coef.store)
	);

	assign regReadData = st.readData;
	assign regReadValid = st.readValid;
	assign gpOut = st.pinOut;
	assign gpOutEnable = st.pinEnable;
	assign bridgeSwitchClosed = st.bridge;

	sequence gpoWritten;
		wrGpo;
	endsequence
	sequence outputsFollow;
		##1 gpOutEnable[3:2] == {2{$past(regWriteData[`GPC_BIT_UPPER_EN])}};
	endsequence

	AST_BRIDGE: assert property (@(posedge clk_sys) disable iff (!reset_n)
		gpoWritten |=> bridgeSwitchClosed == $past(regWriteData[`GPC_BIT_BRIDGE]))
		else $error("Bridge switch does not follow its control bit.");
	AST_BRIDGE_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!wrGpo |=> $stable(bridgeSwitchClosed))
		else $error("Bridge switch changed without a write.");
	AST_UPPER_EN: assert property (@(posedge clk_sys) disable iff (!reset_n)
		gpoWritten |-> outputsFollow)
		else $error("Upper pair enable wrong after write.");
	AST_LOWER_EN: assert property (@(posedge clk_sys) disable iff (!reset_n)
		gpoWritten and !referenceSelect
		|=> gpOutEnable[1:0] == {2{$past(regWriteData[`GPC_BIT_LOWER_EN])}})
		else $error("Lower pair enable wrong after write.");
	AST_TRISTATE_DATA: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(gpOut & ~gpOutEnable) == 4'h0)
		else $error("Data driven on a tristated pin.");
	AST_DATA: assert property (@(posedge clk_sys) disable iff (!reset_n)
		gpoWritten |=> (gpOut & gpOutEnable) == ($past(regWriteData[3:0]) & gpOutEnable))
		else $error("Pin level does not follow its data bit.");
	AST_REFERENCE_SELECT: assert property (@(posedge clk_sys) disable iff (!reset_n)
		referenceSelect |=> gpOutEnable[1:0] == 2'h0)
		else $error("Reference pins still driven.");
	AST_READBACK: assert property (@(posedge clk_sys) disable iff (!reset_n)
		regRead && registerSelect == `GPC_ADDR_GPO && !wrGpo
		|=> regReadValid && (regReadData[3:0] & pairEnMask($past(st.gpControl))) ==
			($past(pinLevelIn) & pairEnMask($past(st.gpControl))))
		else $error("Readback does not show pin levels.");
	AST_CAL_DATA: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(zeroScaleCal || fullScaleCal) |-> coef.wrData == calResult)
		else $error("Calibration result not routed to the coefficient store.");
	AST_SHARED_PAIR: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pseudoMode && channelSelect >= 4'h4 && channelSelect <= 4'h7
		|-> coef.pair == `GPC_LAST_PAIR)
		else $error("Pseudo-differential upper channels not on the shared pair.");
	AST_GPO_WIDTH: assert property (@(posedge clk_sys) disable iff (!reset_n)
		regReadValid && $past(registerSelect) == `GPC_ADDR_GPO |-> regReadData[23:8] == 16'h0000)
		else $error("Output control readback wider than eight bits.");
endmodule

// *** gpc_host_model.sv ***
// Host model that issues register reads and writes on the register port.
`timescale 1ns/1ps
module gpc_host_model
(
	input  wire logic        clk_sys,
	output logic      [2:0]  registerSelect,
	output logic             regWrite,
	output logic             regRead,
	output logic      [23:0] regWriteData,
	input  wire logic [23:0] regReadData,
	input  wire logic        regReadValid
);
	initial
	begin
		registerSelect = 3'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWriteData = 24'h000000;
	end
	// Coefficient writes are only issued while the converter sits idle.
	task automatic wr(input logic [2:0] sel, input logic [23:0] data);
		registerSelect = sel;
		regWriteData = (sel == 3'h5) ? {17'h00000, data[6:0]} : data;
		regWrite = 1'b1;
		@(posedge clk_sys);
		#1 regWrite = 1'b0;
		// A released bus must not keep showing the last value.
		regWriteData = ~regWriteData;
		// One idle edge keeps a following write from raising the strobe it just lowered.
		@(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [2:0] sel, output logic [23:0] data);
		int n;
		registerSelect = sel;
		regRead = 1'b1;
		@(posedge clk_sys);
		#1 regRead = 1'b0;
		n = 0;
		while (regReadValid !== 1'b1 && n < 8)
		begin
			@(posedge clk_sys);
			n++;
		end
		data = regReadData;
		@(posedge clk_sys);
		#1;
	endtask
endmodule

// *** gpc_regs_tb_top.sv ***
// Self-checking bench for the output control and calibration register bank.
`timescale 1ns/1ps
`include "gpc_defines.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module gpc_regs_tb_top
	import gpc_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [2:0]  registerSelect;
	logic        regWrite, regRead, regReadValid, pseudoMode, referenceSelect;
	logic        zeroScaleCal, fullScaleCal, bridgeSwitchClosed;
	logic [23:0] regWriteData, regReadData, calResult, d;
	logic [3:0]  channelSelect, pinLevelIn, gpOut, gpOutEnable, en;
	logic [7:0]  mGpo;
	gpc_coef_t   mOff [5];
	gpc_coef_t   mFull [5];
	logic [31:0] lfsr = 32'h7ba3;
	logic [31:0] r;
	int          num_errors = 0;
	int          compares = 0;

	always #50 clk_sys = ~clk_sys;

	gpc_host_model host_u (.clk_sys, .registerSelect, .regWrite, .regRead, .regWriteData,
		.regReadData, .regReadValid);
	gpc_regs dut_u (.clk_sys, .reset_n, .registerSelect, .regWrite, .regRead, .regWriteData,
		.regReadData, .regReadValid, .channelSelect, .pseudoMode, .referenceSelect,
		.zeroScaleCal, .fullScaleCal, .calResult, .pinLevelIn, .gpOut, .gpOutEnable,
		.bridgeSwitchClosed);

	function logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic int pair_of(input logic [3:0] ch, input logic ps);
		if (ch == 4'h9)
			return 0;
		if (ps && ch >= 4'h4 && ch <= 4'h7)
			return 4;
		return ch[1:0];
	endfunction
	task automatic check_coefs();
		for (int i = 0; i < 10; i++)
		begin
			channelSelect = i[3:0];
			pseudoMode = i[0];
			host_u.rd(3'h6, d);
			`CHK("offset", mOff[pair_of(channelSelect, pseudoMode)], d)
			host_u.rd(3'h7, d);
			`CHK("fullscale", mFull[pair_of(channelSelect, pseudoMode)], d)
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		{channelSelect, pseudoMode, referenceSelect, zeroScaleCal, fullScaleCal} = '0;
		calResult = 24'h000000;
		pinLevelIn = 4'h0;
		mGpo = `GPC_GPO_RESET;
		for (int i = 0; i < 5; i++)
		begin
			mOff[i] = `GPC_OFFSET_RESET;
			mFull[i] = `GPC_FULLSCALE_DEF;
		end
		repeat (2) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		host_u.rd(3'h5, d);
		`CHK("gpo reset", 24'h000000, d)
		check_coefs();
		for (int i = 0; i < 10; i++)
		begin
			channelSelect = i[3:0];
			pseudoMode = i[0];
			r = rnd();
			host_u.wr(3'h6, r[23:0]);
			mOff[pair_of(channelSelect, pseudoMode)] = r[23:0];
			host_u.wr(3'h7, ~r[23:0]);
			mFull[pair_of(channelSelect, pseudoMode)] = ~r[23:0];
			zeroScaleCal = r[1];
			fullScaleCal = r[2];
			r = rnd();
			calResult = r[23:0];
			@(posedge clk_sys);
			if (zeroScaleCal) mOff[pair_of(channelSelect, pseudoMode)] = calResult;
			if (fullScaleCal) mFull[pair_of(channelSelect, pseudoMode)] = calResult;
			#1 {zeroScaleCal, fullScaleCal} = 2'b00;
		end
		for (int i = 0; i < 5; i++)
		begin
			r = rnd();
			host_u.wr(i[2:0], r[23:0]);
		end
		host_u.rd(3'h2, d);
		`CHK("unmapped", 24'h000000, d)
		check_coefs();
		for (int i = 0; i < 40; i++)
		begin
			r = rnd();
			referenceSelect = r[8];
			pinLevelIn = r[12:9];
			host_u.wr(3'h5, r[23:0]);
			mGpo = {1'b0, r[6:0]};
			@(posedge clk_sys);
			#1 en = {{2{mGpo[5]}}, {2{mGpo[4] & ~referenceSelect}}};
			`CHK("gpOutEnable", en, gpOutEnable)
			`CHK("gpOut", mGpo[3:0] & en, gpOut)
			`CHK("bridge", mGpo[6], bridgeSwitchClosed)
			referenceSelect = 1'b0;
			host_u.rd(3'h5, d);
			en = {{2{mGpo[5]}}, {2{mGpo[4]}}};
			`CHK("gpo read", {16'h0000, mGpo[7:4], (en & pinLevelIn) | (~en & mGpo[3:0])}, d)
		end
		end_of_test();
	end

	initial
	begin
		#1000000;
		num_errors++;
		end_of_test();
	end
endmodule
